// File: include/rms_pkg.sv
// Constants and types of the radar mode sequencer
package rms_pkg;
  // Controller clock
  localparam int CLK_MHZ = 40;
  // Times in their own units
  localparam int STEP_NS       = 100;
  localparam int SETTLE_BB_MS  = 5;
  localparam int PLL_SETTLE_US = 20;
  localparam int DET_SETTLE_MS = 50;
  localparam int WAKE_PULSE_NS = 1600;
  localparam int EXT_CLK_KHZ   = 9600;
  // Derived cycle counts (least times round up)
  localparam int STEP_CYC = (STEP_NS * CLK_MHZ + 999) / 1000;
  localparam int BB_CYC   = SETTLE_BB_MS * 1000 * CLK_MHZ;
  localparam int PLLS_CYC = PLL_SETTLE_US * CLK_MHZ;
  localparam int DET_CYC  = DET_SETTLE_MS * 1000 * CLK_MHZ;
  localparam int WAKE_CYC = WAKE_PULSE_NS * CLK_MHZ / 1000;
  // External clock half period: 40 MHz cannot make 9.6 MHz exactly
  localparam int EXTH_CYC = (CLK_MHZ * 1000) / (2 * EXT_CLK_KHZ);
  // Extra external clocks after disable request (16 to 32)
  localparam logic [5:0] EXT_TAIL = 6'h14;
  // Direct control words
  localparam logic [15:0] A_OFF      = 16'h0000;
  localparam logic [15:0] A_SLEEP    = 16'h0900;
  localparam logic [15:0] A_VCO      = 16'h391f;
  localparam logic [15:0] A_PLL      = 16'h3f1f;
  localparam logic [15:0] A_AMP      = 16'h3f3f;
  localparam logic [15:0] A_PLLOFF   = 16'h393f;
  localparam logic [15:0] A_INITAMP  = 16'h373f;
  localparam logic [15:0] A_INITNOA  = 16'h371f;
  localparam logic [15:0] A_INITNOP  = 16'h311f;
  localparam logic [15:0] B_OFF      = 16'h0000;
  localparam logic [15:0] B_INITSMP  = 16'h1037;
  localparam logic [15:0] B_DIV      = 16'h1092;
  localparam logic [15:0] B_SAMPLE   = 16'h1093;
  localparam logic [15:0] B_NODIV    = 16'h0092;
  localparam logic [15:0] B_CW       = 16'h10b3;
  // Bit positions inside direct_ctrl_a / direct_ctrl_b
  localparam int A_PLL_ACTIVE = 9;
  localparam int A_CLK_GATE   = 10;
  localparam int B_DET_ON     = 7;
  // Mode select input codes
  localparam logic [1:0] MS_EXTCLK = 2'h2;
  localparam logic [1:0] MS_NOCLK  = 2'h3;
  // Default lookup of delay fields (cycles)
  localparam logic [31:0] VCO_LUT_DEF  = {16'd80, 16'd40};
  localparam logic [63:0] AMP_LUT_DEF  = {16'd160, 16'd80, 16'd40, 16'd20};
  localparam logic [63:0] ON_LUT_DEF   = {16'd800, 16'd400, 16'd200, 16'd100};
  localparam logic [95:0] REP_LUT_DEF  =
    {24'd80000, 24'd40000, 24'd20000, 24'd10000};
  // Operating modes
  typedef enum logic [1:0] {
    RMS_MODE_PULSED = 2'h0,
    RMS_MODE_CW     = 2'h1,
    RMS_MODE_SPI    = 2'h2
  } rms_mode_t;
  // Sequencer states, one-hot
  typedef enum logic [12:0] {
    S_IDLE    = 13'h0001,
    S_INIT    = 13'h0002,
    S_BBWAIT  = 13'h0004,
    S_PINIT   = 13'h0008,
    S_SLEEP   = 13'h0010,
    S_VCO     = 13'h0020,
    S_LOCK    = 13'h0040,
    S_AMP     = 13'h0080,
    S_SAMPLE  = 13'h0100,
    S_SHUT    = 13'h0200,
    S_CW      = 13'h0400,
    S_SPI     = 13'h0800,
    S_DONE    = 13'h1000
  } rms_state_t;
endpackage

// File: logic/rms_sequencer.sv
// Radar mode sequencer driving the two direct control registers
`timescale 1ns/10ps
// Behaviour
// - Init: amplifier on, wait amp delay, enable sampling.
// - Init waits 5 ms baseband settling, then ends if CW.
// - Pulsed init: detector on, sampling off, then amplifier off 100 ns later.
// - Pulsed init waits 20 us with PLL running before PLL off.
// - Pulsed init ends with 0x311F, 0x0092, 0x0900, 100 ns apart.
// - Pulsed mode starts with a full sleep phase.
// - Active phase writes 0x391F then 0x1092.
// - Wait vco_to_pll_delay, then write 0x3F1F.
// - After lock: 0x3F3F, wait amp delay, 0x1093.
// - Sample for the pulse_on_length on-time.
// - Shutdown writes five words, 100 ns apart.
// - Repetition period runs from active start to active start.
// - Default lookup gives 500 us period, 5 us on-time.
// - PLL clock gate always equals PLL active.
// - External register access stalls the sequencer and its delay counter; repetition and wakeup counters run.
// - Wakeup lasts 1.6 us; fully covered wakeup skips one phase.
// - Detector output held inactive 50 ms after enable.
// - CW: write 0x10B3 then stay inactive.
// - SPI mode: write 0x0000 to direct_ctrl_b, then inactive.
// - SPI mode: external clock on for code 10, off for 11.
// - start_pulsed launches pulsed; clock disable gives extra clocks.
// - Each direct register write takes one 100 ns step, except start_pulsed, which writes both registers in the same cycle.
// - Sequencer halts while chip select is low.
module rms_sequencer
  import rms_pkg::*;
#(
  parameter logic [31:0] VCO_LUT = VCO_LUT_DEF,
  parameter logic [63:0] AMP_LUT = AMP_LUT_DEF,
  parameter logic [63:0] ON_LUT  = ON_LUT_DEF,
  parameter logic [95:0] REP_LUT = REP_LUT_DEF,
  parameter int          BB_CNT  = BB_CYC,
  parameter int          DET_CNT = DET_CYC
) (
  input  wire logic        ref_clk,           // Controller clock
  input  wire logic        rstn,              // Async reset, low
  input  wire logic [1:0]  mode_select_input, // Mode select pin code
  input  wire logic        mode_valid,        // Mode code has been read
  input  wire logic        pll_lock,          // PLL lock detect
  input  wire logic        spi_cs_n,          // External chip select
  input  wire logic        reg_busy,          // External access pending
  input  wire logic        start_pulsed,      // Launch pulsed from SPI
  input  wire logic        ext_clock_disable, // Stop external clock
  input  wire logic [11:0] timing_cfg,        // Timing field register
  output logic [15:0]      direct_ctrl_a,     // Direct control A
  output logic [15:0]      direct_ctrl_b,     // Direct control B
  output logic             ext_clk,           // External clock out
  output logic             detect_allowed,    // Detector output enable
  output logic             init_done          // Init sequence left
);

  // Table lookup of delay fields
  function automatic logic [23:0] lut16(input logic [63:0] t,
                                        input logic [1:0] i);
    lut16 = {8'h00, t[i*16 +: 16]};
  endfunction

  // Synchronised pins
  logic [1:0] cs_s, busy_s, lock_s, start_s, dis_s;
  logic [1:0] ms0, ms1;
  logic       halt;
  rms_state_t state, next_state;
  rms_mode_t  mode, next_mode;
  logic [15:0] next_a, next_b;
  logic [2:0]  step, next_step;
  logic [23:0] cnt, next_cnt;
  logic [23:0] rep, next_rep;
  logic [6:0]  wake, next_wake;
  logic        wake_seen, next_wake_seen;
  logic        next_done;

  // Two flip-flop synchronisers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cs_s    <= 2'h3;
      busy_s  <= 2'h0;
      lock_s  <= 2'h0;
      start_s <= 2'h0;
      dis_s   <= 2'h0;
      ms0     <= 2'h0;
      ms1     <= 2'h0;
    end else begin
      cs_s    <= {cs_s[0], spi_cs_n};
      busy_s  <= {busy_s[0], reg_busy};
      lock_s  <= {lock_s[0], pll_lock};
      start_s <= {start_s[0], start_pulsed};
      dis_s   <= {dis_s[0], ext_clock_disable};
      ms0     <= mode_select_input;
      ms1     <= ms0;
    end
  end

  assign halt = !cs_s[1] || busy_s[1];

  // Sequencer next values
  always_comb begin
    next_state     = state;
    next_mode      = mode;
    next_a         = direct_ctrl_a;
    next_b         = direct_ctrl_b;
    next_step      = step;
    // Delay counter freezes while halted
    next_cnt       = (!halt && cnt != 24'h0) ? cnt - 24'h1 : cnt;
    next_done      = init_done;
    // Wakeup counter runs free of the stall and of the active phase
    next_rep       = (rep != 24'h0) ? rep - 24'h1 : rep;
    next_wake      = (wake != 7'h0) ? wake - 7'h1 : wake;
    next_wake_seen = wake_seen;
    if (rep == 24'h1) begin
      next_rep  = REP_LUT[timing_cfg[11:10]*24 +: 24];
      next_wake = 7'(WAKE_CYC);
      next_wake_seen = 1'b0;
    end
    if (!halt && cnt == 24'h0) begin
      case (state)
        S_IDLE: if (mode_valid) begin
          if (ms1[1]) begin
            next_mode  = RMS_MODE_SPI;
            next_state = S_SPI;
          end else begin
            next_mode  = ms1[0] ? RMS_MODE_CW : RMS_MODE_PULSED;
            next_state = S_INIT;
          end
        end
        S_INIT: begin
          next_step = step + 3'h1;
          next_cnt  = 24'(STEP_CYC - 1);
          case (step)
            3'h0: next_a = A_INITAMP;
            3'h1: next_cnt = lut16(AMP_LUT, timing_cfg[5:4]);
            default: begin
              next_b     = B_INITSMP;
              next_cnt   = 24'(BB_CNT);
              next_step  = 3'h0;
              next_state = S_BBWAIT;
            end
          endcase
        end
        S_BBWAIT: begin
          next_state = (mode == RMS_MODE_CW) ? S_CW : S_PINIT;
        end
        S_PINIT: begin
          next_step = step + 3'h1;
          next_cnt  = 24'(STEP_CYC - 1);
          case (step)
            3'h0: next_b = B_DIV;
            3'h1: begin
              next_a   = A_INITNOA;
              next_cnt = 24'(PLLS_CYC);
            end
            3'h2: next_a = A_INITNOP;
            3'h3: next_b = B_NODIV;
            default: begin
              next_a     = A_SLEEP;
              next_done  = 1'b1;
              next_step  = 3'h0;
              next_state = S_SLEEP;
              next_rep   = REP_LUT[timing_cfg[11:10]*24 +: 24];
            end
          endcase
        end
        S_SLEEP: if (wake != 7'h0 && !wake_seen) begin
          next_wake_seen = 1'b1;
          next_a         = A_VCO;
          next_cnt       = 24'(STEP_CYC - 1);
          next_state     = S_VCO;
        end
        S_VCO: begin
          next_step = step + 3'h1;
          case (step)
            3'h0: begin
              next_b   = B_DIV;
              next_cnt = 24'(VCO_LUT[timing_cfg[6]*16 +: 16]);
            end
            default: begin
              next_a     = A_PLL;
              next_step  = 3'h0;
              next_state = S_LOCK;
            end
          endcase
        end
        S_LOCK: if (lock_s[1]) begin
          next_a     = A_AMP;
          next_cnt   = lut16(AMP_LUT, timing_cfg[5:4]);
          next_state = S_AMP;
        end
        S_AMP: begin
          next_b     = B_SAMPLE;
          next_cnt   = lut16(ON_LUT, timing_cfg[9:8]);
          next_state = S_SAMPLE;
        end
        S_SAMPLE: begin
          next_b     = B_DIV;
          next_cnt   = 24'(STEP_CYC - 1);
          next_step  = 3'h0;
          next_state = S_SHUT;
        end
        S_SHUT: begin
          next_step = step + 3'h1;
          next_cnt  = 24'(STEP_CYC - 1);
          case (step)
            3'h0: next_a = A_PLLOFF;
            3'h1: next_a = A_VCO;
            3'h2: next_b = B_NODIV;
            default: begin
              next_a     = A_SLEEP;
              next_step  = 3'h0;
              next_state = S_SLEEP;
            end
          endcase
        end
        S_CW: begin
          next_b     = B_CW;
          next_done  = 1'b1;
          next_state = S_DONE;
        end
        S_SPI: begin
          next_a    = A_OFF;
          next_b    = B_OFF;
          next_done = 1'b1;
          if (start_s[1]) begin
            next_mode  = RMS_MODE_PULSED;
            next_b     = B_NODIV;
            next_a     = A_SLEEP;
            next_state = S_SLEEP;
            next_rep   = REP_LUT[timing_cfg[11:10]*24 +: 24];
          end
        end
        S_DONE: next_state = S_DONE;
        default: next_state = S_IDLE;
      endcase
    end
  end

  // Sequencer registers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state         <= S_IDLE;
      mode          <= RMS_MODE_PULSED;
      direct_ctrl_a <= A_OFF;
      direct_ctrl_b <= B_OFF;
      step          <= 3'h0;
      cnt           <= 24'h0;
      rep           <= 24'h0;
      wake          <= 7'h0;
      wake_seen     <= 1'b0;
      init_done     <= 1'b0;
    end else begin
      state         <= next_state;
      mode          <= next_mode;
      direct_ctrl_a <= next_a;
      direct_ctrl_b <= next_b;
      step          <= next_step;
      cnt           <= next_cnt;
      rep           <= next_rep;
      wake          <= next_wake;
      wake_seen     <= next_wake_seen;
      init_done     <= next_done;
    end
  end

  // Detector settle timer and external clock divider
  logic [21:0] det_cnt, next_det_cnt;
  logic        next_allowed;
  logic [2:0]  div, next_div;
  logic        next_ext;
  logic        clk_on, next_clk_on;
  logic [5:0]  tail, next_tail;
  always_comb begin
    next_det_cnt = det_cnt;
    next_allowed = detect_allowed;
    if (!direct_ctrl_b[B_DET_ON]) begin
      next_det_cnt = 22'(DET_CNT);
      next_allowed = 1'b0;
    end else if (det_cnt != 22'h0) begin
      next_det_cnt = det_cnt - 22'h1;
    end else begin
      next_allowed = 1'b1;
    end
    next_clk_on = clk_on;
    next_tail   = tail;
    if (mode == RMS_MODE_SPI && ms1 == MS_EXTCLK && tail == 6'h0) begin
      next_clk_on = 1'b1;
    end
    if (ms1 == MS_NOCLK) begin
      next_clk_on = 1'b0;
    end
    if (clk_on && dis_s[1] && tail == 6'h0) begin
      next_tail = EXT_TAIL;
    end
    next_div = div;
    next_ext = ext_clk;
    if (clk_on) begin
      next_div = (div == 3'(EXTH_CYC - 1)) ? 3'h0 : div + 3'h1;
      if (div == 3'(EXTH_CYC - 1)) begin
        next_ext = !ext_clk;
        if (ext_clk && tail != 6'h0) begin
          next_tail = tail - 6'h1;
          if (tail == 6'h1) begin
            next_clk_on = 1'b0;
            next_tail   = 6'h3f;
          end
        end
      end
    end else begin
      next_ext = 1'b0;
    end
  end

  // Detector and clock registers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      det_cnt        <= 22'h0;
      detect_allowed <= 1'b0;
      div            <= 3'h0;
      ext_clk        <= 1'b0;
      clk_on         <= 1'b0;
      tail           <= 6'h0;
    end else begin
      det_cnt        <= next_det_cnt;
      detect_allowed <= next_allowed;
      div            <= next_div;
      ext_clk        <= next_ext;
      clk_on         <= next_clk_on;
      tail           <= next_tail;
    end
  end

endmodule

// File: tb/rms_checker.sv
// Port assertions of the radar mode sequencer
`timescale 1ns/10ps
module rms_checker
  import rms_pkg::*;
#(
  parameter int DET_CNT = 50
) (
  input wire logic        ref_clk,           // Clock
  input wire logic        rstn,              // Reset, low
  input wire logic [1:0]  mode_select_input, // Mode code
  input wire logic        mode_valid,        // Mode read
  input wire logic        pll_lock,          // Lock detect
  input wire logic        spi_cs_n,          // Chip select
  input wire logic        reg_busy,          // Access pending
  input wire logic [15:0] direct_ctrl_a,     // Control A
  input wire logic [15:0] direct_ctrl_b,     // Control B
  input wire logic        ext_clk,           // Clock out
  input wire logic        detect_allowed     // Detector enable
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  int det_cnt;
  int next_det_cnt;
  // Cycles since detector enable, saturating
  always_comb begin
    next_det_cnt = 0;
    if (direct_ctrl_b[B_DET_ON])
      next_det_cnt = (det_cnt < DET_CNT) ? det_cnt + 1 : det_cnt;
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn)
      det_cnt <= 0;
    else
      det_cnt <= next_det_cnt;
  end
  // Steps of the pulsed shutdown chain
  sequence s_wr_a(logic [15:0] v);
    $changed(direct_ctrl_a) && direct_ctrl_a == v;
  endsequence
  sequence s_shut;
    ##4 direct_ctrl_a == A_PLLOFF ##4 direct_ctrl_a == A_VCO
    ##4 direct_ctrl_b == B_NODIV ##4 direct_ctrl_a == A_SLEEP;
  endsequence
  chk_gate_active: assert property (
    direct_ctrl_a[A_CLK_GATE] == direct_ctrl_a[A_PLL_ACTIVE])
    else $error("clock gate differs from PLL active");
  chk_det_hold: assert property (
    detect_allowed |-> det_cnt >= DET_CNT - 1)
    else $error("detector output enabled too early");
  chk_halt_cs: assert property (
    !spi_cs_n [*5] |=> $stable(direct_ctrl_a) && $stable(direct_ctrl_b))
    else $error("control changed while chip select low");
  chk_halt_busy: assert property (
    reg_busy [*5] |=> $stable(direct_ctrl_a) && $stable(direct_ctrl_b))
    else $error("control changed during register access");
  chk_step_gap: assert property (
    ($changed(direct_ctrl_a) || $changed(direct_ctrl_b)) |=>
      !($changed(direct_ctrl_a) || $changed(direct_ctrl_b)) [*3])
    else $error("control writes closer than one step");
  chk_amp_lock: assert property (
    s_wr_a(A_AMP) |-> $past(pll_lock, 2))
    else $error("amplifier enabled without lock");
  chk_samp_amp: assert property (
    ($changed(direct_ctrl_b) && direct_ctrl_b == B_SAMPLE)
      |-> direct_ctrl_a == A_AMP)
    else $error("sampling started with amplifier off");
  chk_vco_div: assert property (
    s_wr_a(A_VCO) ##0 $past(direct_ctrl_a) == A_SLEEP
      |-> ##4 direct_ctrl_b == B_DIV)
    else $error("divider bias not one step after wakeup");
  chk_shut_order: assert property (
    ($changed(direct_ctrl_b) && direct_ctrl_b == B_DIV
      && $past(direct_ctrl_b) == B_SAMPLE) |-> s_shut)
    else $error("shutdown order or spacing wrong");
  chk_cw_quiet: assert property (
    ($changed(direct_ctrl_b) && direct_ctrl_b == B_CW) |=>
      ($stable(direct_ctrl_a) && $stable(direct_ctrl_b)) [*8])
    else $error("sequencer active after continuous wave entry");
  chk_noclk_off: assert property (
    (mode_valid && mode_select_input == MS_NOCLK) [*4] |-> !ext_clk)
    else $error("external clock running with code 11");
endmodule
bind rms_sequencer rms_checker #(.DET_CNT(DET_CNT)) u_chk (
  .ref_clk(ref_clk), .rstn(rstn), .mode_select_input(mode_select_input),
  .mode_valid(mode_valid), .pll_lock(pll_lock), .spi_cs_n(spi_cs_n),
  .reg_busy(reg_busy), .direct_ctrl_a(direct_ctrl_a),
  .direct_ctrl_b(direct_ctrl_b), .ext_clk(ext_clk),
  .detect_allowed(detect_allowed));

// File: tb/rms_mcu_model.sv
// Behavioural external controller driving the access lines
`timescale 1ns/10ps
module rms_mcu_model (
  input  wire logic ref_clk,           // Controller clock
  output logic      spi_cs_n,          // Chip select
  output logic      reg_busy,          // Access in progress
  output logic      start_pulsed,      // Pulsed launch bit
  output logic      ext_clock_disable  // Clock stop bit
);
  initial begin
    spi_cs_n = 1'b1;
    reg_busy = 1'b0;
    start_pulsed = 1'b0;
    ext_clock_disable = 1'b0;
  end
  // One access of n cycles; launch also sets the pulsed launch and clock stop bits
  task automatic access(input int n, input logic cs, input logic launch);
    @(posedge ref_clk);
    #1;
    spi_cs_n = !cs;
    reg_busy = !cs || launch;
    start_pulsed = launch || start_pulsed;
    ext_clock_disable = launch || ext_clock_disable;
    repeat (n) @(posedge ref_clk);
    #1;
    spi_cs_n = 1'b1;
    reg_busy = 1'b0;
  endtask
endmodule

// File: tb/rms_sequencer_tb.sv
// Self-checking testbench of the radar mode sequencer
`timescale 1ns/10ps
module rms_sequencer_tb;
  import rms_pkg::*;
  localparam int DET = 50;
  localparam logic [16:0] EXP [17] = '{{1'b0, A_INITAMP}, {1'b1, B_INITSMP},
    {1'b1, B_DIV}, {1'b0, A_INITNOA}, {1'b0, A_INITNOP}, {1'b1, B_NODIV},
    {1'b0, A_SLEEP}, {1'b0, A_VCO}, {1'b1, B_DIV}, {1'b0, A_PLL},
    {1'b0, A_AMP}, {1'b1, B_SAMPLE}, {1'b1, B_DIV}, {1'b0, A_PLLOFF},
    {1'b0, A_VCO}, {1'b1, B_NODIV}, {1'b0, A_SLEEP}};
  logic        ref_clk = 1'b0;
  logic        rstn = 1'b0;
  logic [1:0]  msel = 2'h0;
  logic [11:0] tcfg = 12'h670;
  logic        mvalid = 1'b0;
  logic        lock = 1'b0;
  logic        spi_cs_n, reg_busy, start_pulsed, ext_dis;
  logic [15:0] ctl_a, ctl_b, pa, pb;
  logic        ext_clk, det_ok, init_done, pe, pd, f;
  logic [16:0] wv [$];
  int          wt [$];
  int          cyc = 0, lock_n = 0, det_t = 0, clk_n = 0;
  int          n_errors = 0, compares = 0;
  always #12.5 ref_clk = ~ref_clk;
  rms_mcu_model u_mcu (.ref_clk(ref_clk), .spi_cs_n(spi_cs_n),
    .reg_busy(reg_busy), .start_pulsed(start_pulsed),
    .ext_clock_disable(ext_dis));
  rms_sequencer #(.VCO_LUT({16'd16, 16'd8}),
    .AMP_LUT({16'd20, 16'd16, 16'd12, 16'd8}),
    .ON_LUT({16'd80, 16'd60, 16'd40, 16'd24}),
    .REP_LUT({24'd700, 24'd600, 24'd500, 24'd400}),
    .BB_CNT(50), .DET_CNT(DET)) u_dut (
    .ref_clk(ref_clk), .rstn(rstn), .mode_select_input(msel),
    .mode_valid(mvalid), .pll_lock(lock), .spi_cs_n(spi_cs_n),
    .reg_busy(reg_busy), .start_pulsed(start_pulsed),
    .ext_clock_disable(ext_dis), .timing_cfg(tcfg),
    .direct_ctrl_a(ctl_a), .direct_ctrl_b(ctl_b), .ext_clk(ext_clk),
    .detect_allowed(det_ok), .init_done(init_done));
  // Write log, clock edges, detector rise and timeout
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc > 30000) begin
      fail("timeout");
      finish_test;
    end
    if (ext_clk && !pe) clk_n++;
    if (det_ok && !pd) det_t = cyc;
    pe <= ext_clk;
    pd <= det_ok;
    pa <= rstn ? ctl_a : 16'h0;
    pb <= rstn ? ctl_b : 16'h0;
    if (rstn && ctl_a !== pa) begin
      wv.push_back({1'b0, ctl_a});
      wt.push_back(cyc);
    end
    if (rstn && ctl_b !== pb) begin
      wv.push_back({1'b1, ctl_b});
      wt.push_back(cyc);
    end
  end
  // Lock detect follows PLL active after a settling time
  always @(posedge ref_clk) begin
    #1;
    lock_n = ctl_a[A_PLL_ACTIVE] ? lock_n + 1 : 0;
    lock = lock_n > 20;
  end
  task automatic fail(input string m);
    n_errors++;
    $display("ERROR %0t: %s", $time, m);
  endtask
  task automatic cmp_rng(input int got, input int lo, input int hi);
    compares++;
    if (got < lo || got > hi) fail($sformatf("count %0d", got));
  endtask
  task automatic cmp_w(input int i, input logic [16:0] e);
    compares++;
    if (i >= wv.size() || wv[i] !== e) fail($sformatf("write %0d", i));
  endtask
  task automatic cmp_bit(input logic [15:0] got, input logic [15:0] e);
    compares++;
    if (got !== e) fail($sformatf("got %h want %h", got, e));
  endtask
  function automatic int gap(input int i, input int j);
    return (j < wt.size()) ? wt[j] - wt[i] : -1;
  endfunction
  task automatic wait_ev(input int n);
    for (int k = 0; k < 5000 && wv.size() <= n; k++) @(posedge ref_clk);
    #1;
    if (wv.size() <= n) fail("event wait ran out");
  endtask
  task automatic do_reset(input logic [1:0] m);
    @(posedge ref_clk);
    #1;
    rstn = 1'b0;
    mvalid = 1'b0;
    msel = m;
    repeat (3) @(posedge ref_clk);
    #1;
    wv.delete();
    wt.delete();
    rstn = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    mvalid = 1'b1;
  endtask
  task automatic finish_test;
    $display("n_errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Pulsed, continuous wave and both manual mode codes in turn
  initial begin
    do_reset(2'h0);
    wait_ev(17);
    for (int i = 0; i < 17; i++) cmp_w(i, EXP[i]);
    cmp_rng(gap(0, 1), 20, 28);
    cmp_rng(gap(1, 2), 50, 58);
    cmp_rng(gap(2, 3), 4, 4);
    cmp_rng(gap(3, 4), PLLS_CYC, PLLS_CYC + 8);
    cmp_rng(gap(4, 6), 8, 8);
    cmp_rng(gap(6, 7), 500, 508);
    cmp_rng(gap(7, 9), 16, 24);
    cmp_rng(gap(10, 11), 20, 28);
    cmp_rng(gap(11, 12), 60, 68);
    cmp_rng(gap(12, 16), 16, 16);
    cmp_rng(gap(7, 17), 500, 500);
    cmp_rng(det_t - wt[2], DET, DET + 8);
    while (cyc < wt[17] + 480) @(posedge ref_clk);
    u_mcu.access(120, 1'b1, 1'b0);
    wait_ev(31);
    u_mcu.access(40, 1'b0, 1'b0);
    wait_ev(41);
    u_mcu.access(40, 1'b1, 1'b0);
    wait_ev(42);
    cmp_rng(gap(17, 27), 1000, 1000);
    cmp_rng(gap(31, 32), 96, 112);
    cmp_rng(gap(27, 37), 500, 500);
    cmp_rng(gap(41, 42), 96, 112);
    tcfg = 12'h600;
    do_reset(2'h1);
    wait_ev(2);
    repeat (200) @(posedge ref_clk);
    cmp_w(0, {1'b0, A_INITAMP});
    cmp_w(2, {1'b1, B_CW});
    cmp_rng(wv.size(), 3, 3);
    cmp_rng(gap(1, 2), 50, 58);
    cmp_rng(gap(0, 1), 8, 16);
    do_reset(2'h3);
    repeat (100) @(posedge ref_clk);
    clk_n = 0;
    repeat (100) @(posedge ref_clk);
    cmp_rng(clk_n, 0, 0);
    cmp_bit(ctl_a | ctl_b, 16'h0);
    cmp_bit({15'h0, init_done}, 16'h1);
    do_reset(2'h2);
    repeat (100) @(posedge ref_clk);
    clk_n = 0;
    repeat (100) @(posedge ref_clk);
    cmp_rng(clk_n, 20, 30);
    clk_n = 0;
    u_mcu.access(8, 1'b1, 1'b1);
    repeat (2500) @(posedge ref_clk);
    cmp_rng(clk_n, 16, 32);
    f = 1'b0;
    foreach (wv[i]) if (wv[i] === {1'b0, A_VCO}) f = 1'b1;
    cmp_bit({15'h0, f}, 16'h1);
    finish_test;
  end
endmodule
